// *** rtl/gst_pkg.sv ***
`default_nettype none

package gst_pkg;

	// Register bus geometry.
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int COUNT_W = 16;
	localparam int PSC_W = 3;
	localparam int INT_W = 1;

	// Register offsets.
	localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_GATE = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 3'h5;

	// Clock source select codes.
	localparam logic [1:0] CLK_INSTR = 2'h0;
	localparam logic [1:0] CLK_SYSTEM = 2'h1;
	localparam logic [1:0] CLK_EXTERNAL = 2'h2;
	localparam logic [1:0] CLK_RESERVED = 2'h3;

	// Gate source select codes.
	localparam logic [1:0] GATE_SRC_PIN = 2'h0;
	localparam logic [1:0] GATE_SRC_TIMER8 = 2'h1;
	localparam logic [1:0] GATE_SRC_CMP1 = 2'h2;
	localparam logic [1:0] GATE_SRC_CMP2 = 2'h3;

	// The instruction clock is a quarter of the system clock.
	localparam int INSTR_DIV = 4;
	localparam int INSTR_DIV_W = 2;
	localparam logic [INSTR_DIV_W-1:0] INSTR_LAST = INSTR_DIV_W'(INSTR_DIV - 1);

	localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hffff;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [PSC_W-1:0] PSC_ZERO = 3'h0;
	localparam int STAT_OVERFLOW = 0;

	typedef struct packed {
		logic [1:0] clock_source_select;
		logic [1:0] prescale_select;
		logic       dedicated_osc_enable;
		logic       async_mode;
		logic       spare;
		logic       counter_on;
	} gst_ctrl_t;

	typedef struct packed {
		logic       gate_enable_mode;
		logic       gate_polarity;
		logic [3:0] spare;
		logic [1:0] gate_source_select;
	} gst_gate_t;

	localparam gst_ctrl_t CTRL_RESET = 8'h00;
	localparam gst_gate_t GATE_RESET = 8'h00;

	// Asynchronous pins, in the order they enter the synchroniser.
	typedef struct packed {
		logic external_count_pin;
		logic dedicated_osc_in;
		logic gate_pin;
		logic cmp1_out;
		logic cmp2_out;
	} gst_pins_t;

endpackage

`default_nettype wire

// *** rtl/gst_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module gst_sync #(
	parameter int WIDTH = 5
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Levels in and out.
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// Each bit gets its own pair of flops; stage1 feeds stage two only.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				stage1[i] <= 1'h0;
				sync_out[i] <= 1'h0;
			end else begin
				stage1[i] <= async_in[i];
				sync_out[i] <= stage1[i];
			end
		end
	end

endmodule
`default_nettype wire

// *** rtl/gst_timer.sv ***
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - A 16-bit up-counter, software reads and writes it as high and low bytes.
// - Writing either count byte immediately replaces those bits of the running count.
// - Internal sources count once per instruction cycle (00) or once per system cycle (01), after prescaling.
// - External source counts on each selected rising edge of that source.
// - Off when on bit is 0; always counts without gating; else only when gated.
// - Overflow wakes the processor only with external clock in asynchronous operation.
// - Clock select: 00 instruction, 01 system, 10 oscillator or pin, 11 reserved.
// - Prescaler divides by 1, 2, 4, 8; hidden; cleared by count byte writes.
// - Gated, counts only while gate level equals polarity bit, else holds.
// - Gate source: 00 pin, 01 timer8 overflow, 10 comparator 1, 11 comparator 2.
module gst_timer
	import gst_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Register port.
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output var  logic [DATA_W-1:0] reg_rdata,
	// Pins and on-chip sources.
	input  wire gst_pins_t         pins,
	input  wire logic              timer8_overflow,
	input  wire logic              sleep_active,
	// Events.
	output var  logic              irq,
	output var  logic              wake_req
);

	function automatic logic [PSC_W-1:0] psc_mask(input logic [1:0] sel);
		psc_mask = PSC_W'((4'h1 << sel) - 4'h1);
	endfunction

	gst_pins_t                pins_s;
	gst_ctrl_t                ctrl, next_ctrl;
	gst_gate_t                gate, next_gate;
	logic [COUNT_W-1:0]       count, next_count;
	logic [PSC_W-1:0]         psc, next_psc;
	logic [INSTR_DIV_W-1:0]   div, next_div;
	logic                     ext_prev, next_ext_prev;
	logic [INT_W-1:0]         status, next_status;
	logic [INT_W-1:0]         mask, next_mask;
	logic [DATA_W-1:0]        next_rdata;
	logic                     next_irq, next_wake;
	logic                     ext_src, ext_rise, raw_tick, gate_lvl, gate_ok;
	logic                     running, enable, inc, ovf_evt, wr_low, wr_high;

	gst_sync #(
		.WIDTH($bits(gst_pins_t))
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(pins),
		.sync_out(pins_s)
	);

	always_comb begin
		wr_low = reg_wr && (reg_addr == ADDR_COUNT_LOW);
		wr_high = reg_wr && (reg_addr == ADDR_COUNT_HIGH);
		// The oscillator takes the place of the count pin when enabled.
		ext_src = ctrl.dedicated_osc_enable ? pins_s.dedicated_osc_in
			: pins_s.external_count_pin;
		ext_rise = ext_src && !ext_prev;
		next_ext_prev = ext_src;
		next_div = (div == INSTR_LAST) ? '0 : INSTR_DIV_W'(div + 2'h1);
		case (ctrl.clock_source_select)
			CLK_INSTR: raw_tick = (div == INSTR_LAST);
			CLK_SYSTEM: raw_tick = 1'h1;
			CLK_EXTERNAL: raw_tick = ext_rise;
			default: raw_tick = 1'h0;
		endcase
		case (gate.gate_source_select)
			GATE_SRC_PIN: gate_lvl = pins_s.gate_pin;
			GATE_SRC_TIMER8: gate_lvl = timer8_overflow;
			GATE_SRC_CMP1: gate_lvl = pins_s.cmp1_out;
			GATE_SRC_CMP2: gate_lvl = pins_s.cmp2_out;
			default: gate_lvl = 1'h0;
		endcase
		gate_ok = !gate.gate_enable_mode || (gate_lvl == gate.gate_polarity);
		// In sleep only an asynchronous external count keeps running.
		running = !sleep_active
			|| (ctrl.async_mode && ctrl.clock_source_select == CLK_EXTERNAL);
		enable = ctrl.counter_on && gate_ok && running;
		// Only the selected low bits are compared, so a prescale change mid-count
		// stretches at most one period instead of waiting for the counter to wrap.
		inc = enable && raw_tick
			&& ((psc & psc_mask(ctrl.prescale_select)) == psc_mask(ctrl.prescale_select));
		next_psc = psc;
		if (wr_low || wr_high) begin
			next_psc = PSC_ZERO;
		end else if (enable && raw_tick) begin
			next_psc = inc ? PSC_ZERO : PSC_W'(psc + 3'h1);
		end
		next_count = count;
		ovf_evt = 1'h0;
		if (wr_low || wr_high) begin
			// A write beats a coincident increment.
			if (wr_low) begin
				next_count[DATA_W-1:0] = reg_wdata;
			end
			if (wr_high) begin
				next_count[COUNT_W-1:DATA_W] = reg_wdata;
			end
		end else if (inc) begin
			next_count = COUNT_W'(count + COUNT_ONE);
			ovf_evt = (count == COUNT_ALL_ONES);
		end
	end

	always_comb begin
		next_ctrl = ctrl;
		next_gate = gate;
		next_mask = mask;
		next_status = status;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_CONTROL: next_ctrl = reg_wdata;
				ADDR_GATE: next_gate = reg_wdata;
				ADDR_INT_MASK: next_mask = reg_wdata[INT_W-1:0];
				ADDR_INT_STATUS: next_status = status & ~reg_wdata[INT_W-1:0];
				default: next_mask = mask;
			endcase
		end
		// Setting comes after clearing so a coincident overflow is kept.
		if (ovf_evt) begin
			next_status[STAT_OVERFLOW] = 1'h1;
		end
		next_irq = |(next_status & next_mask);
		next_wake = ovf_evt && sleep_active && ctrl.async_mode
			&& (ctrl.clock_source_select == CLK_EXTERNAL);
		next_rdata = DATA_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_COUNT_LOW: next_rdata = count[DATA_W-1:0];
				ADDR_COUNT_HIGH: next_rdata = count[COUNT_W-1:DATA_W];
				ADDR_CONTROL: next_rdata = ctrl;
				ADDR_GATE: next_rdata = gate;
				ADDR_INT_STATUS: next_rdata = DATA_W'(status);
				ADDR_INT_MASK: next_rdata = DATA_W'(mask);
				default: next_rdata = DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl <= CTRL_RESET;
			gate <= GATE_RESET;
			count <= '0;
			psc <= PSC_ZERO;
			div <= '0;
			ext_prev <= 1'h0;
			status <= '0;
			mask <= '0;
			reg_rdata <= DATA_ZERO;
			irq <= 1'h0;
			wake_req <= 1'h0;
		end else begin
			ctrl <= next_ctrl;
			gate <= next_gate;
			count <= next_count;
			psc <= next_psc;
			div <= next_div;
			ext_prev <= next_ext_prev;
			status <= next_status;
			mask <= next_mask;
			reg_rdata <= next_rdata;
			irq <= next_irq;
			wake_req <= next_wake;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_low_write_loads: assert property (
		wr_low |=> count[DATA_W-1:0] == $past(reg_wdata))
		else $error("low byte write not loaded");
	a_high_write_loads: assert property (
		wr_high |=> count[COUNT_W-1:DATA_W] == $past(reg_wdata))
		else $error("high byte write not loaded");
	a_off_holds_count: assert property (
		!ctrl.counter_on && !reg_wr |=> $stable(count))
		else $error("counter moved while off");
	a_gate_closed_holds: assert property (
		ctrl.counter_on && gate.gate_enable_mode && gate_lvl != gate.gate_polarity
		&& !reg_wr |=> $stable(count))
		else $error("counter moved while gate closed");
	a_write_clears_psc: assert property (
		(wr_low || wr_high) |=> psc == PSC_ZERO)
		else $error("prescaler not cleared by count write");
	a_system_clock_rate: assert property (
		ctrl.counter_on && !gate.gate_enable_mode && !sleep_active && !reg_wr
		&& ctrl.clock_source_select == CLK_SYSTEM && ctrl.prescale_select == 2'h0
		|=> count == COUNT_W'($past(count) + COUNT_ONE))
		else $error("system clock did not count every cycle");
	a_instr_spacing: assert property (
		inc && ctrl.clock_source_select == CLK_INSTR |=> !inc [*3])
		else $error("instruction clock counted too fast");
	a_ext_needs_edge: assert property (
		ctrl.clock_source_select == CLK_EXTERNAL && !ext_rise |-> !inc)
		else $error("external count without an edge");
	a_overflow_sets_flag: assert property (
		ovf_evt ##1 mask[STAT_OVERFLOW] |-> status[STAT_OVERFLOW] && irq)
		else $error("overflow flag or interrupt missing");
	a_wake_only_async: assert property (
		wake_req |-> $past(ctrl.async_mode) && $past(sleep_active))
		else $error("wake without asynchronous sleep count");
	a_timer8_gate_path: assert property (
		ctrl.counter_on && gate.gate_enable_mode && !reg_wr
		&& gate.gate_source_select == GATE_SRC_TIMER8
		&& timer8_overflow != gate.gate_polarity |=> $stable(count))
		else $error("timer8 gate source not routed");

endmodule
`default_nettype wire

// *** verif/gst_timer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module gst_timer_tb_top
	import gst_pkg::*;
;
	logic               clk = 1'b0;
	logic               sys_rst = 1'b1;
	logic [ADDR_W-1:0]  reg_addr = '0;
	logic [DATA_W-1:0]  reg_wdata = '0;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [DATA_W-1:0]  reg_rdata;
	gst_pins_t          pins = '0;
	logic               t8_ovf = 1'b0;
	logic               asleep = 1'b0;
	logic               irq;
	logic               wake_req;
	int                 n_fail = 0;
	int                 num_checks = 0;
	logic [DATA_W-1:0]  rd;
	logic [COUNT_W-1:0] cnt;
	logic               seen;

	always #5 clk = ~clk;

	gst_timer dut (
		.clk             (clk),
		.sys_rst         (sys_rst),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.reg_rdata       (reg_rdata),
		.pins            (pins),
		.timer8_overflow (t8_ovf),
		.sleep_active    (asleep),
		.irq             (irq),
		.wake_req        (wake_req)
	);

	task automatic end_sim();
		if (n_fail == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdr(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	task automatic rdcnt();
		rdr(ADDR_COUNT_LOW);
		cnt[7:0] = rd;
		rdr(ADDR_COUNT_HIGH);
		cnt[15:8] = rd;
	endtask

	task automatic setcnt(input logic [15:0] v);
		wr(ADDR_COUNT_LOW, v[7:0]);
		wr(ADDR_COUNT_HIGH, v[15:8]);
	endtask

	// The on bit is live for exactly k sampling edges, so k system ticks are seen.
	task automatic run(input logic [7:0] ctrl, input int k);
		wr(ADDR_CONTROL, ctrl | 8'h01);
		repeat (k - 2) @(posedge clk);
		wr(ADDR_CONTROL, ctrl & 8'hfe);
	endtask

	// Pulses are four clocks wide so each survives the two-flop synchroniser.
	task automatic pulses(input gst_pins_t p, input int n);
		repeat (n) begin
			@(posedge clk);
			pins <= p;
			repeat (4) @(posedge clk);
			pins <= '0;
			repeat (4) @(posedge clk);
		end
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		$display("[FAIL] %0t run did not finish", $time);
		end_sim();
	end

	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		for (int a = 0; a < 7; a++) begin
			rdr(3'(a));
			check(16'(rd), 16'h0000, "reset value");
		end
		wr(ADDR_CONTROL, 8'hfe);
		rdr(ADDR_CONTROL);
		check(16'(rd), 16'h00fe, "control readback");
		wr(ADDR_GATE, 8'hff);
		rdr(ADDR_GATE);
		check(16'(rd), 16'h00ff, "gate readback");
		wr(3'h6, 8'hff);
		rdr(3'h6);
		check(16'(rd), 16'h0000, "unmapped read");
		wr(ADDR_GATE, 8'h00);
		setcnt(16'ha55a);
		wr(ADDR_COUNT_HIGH, 8'h3c);
		rdcnt();
		check(cnt, 16'h3c5a, "byte write");
		for (int cs = 0; cs < 4; cs++) begin
			for (int ps = 0; ps < 4; ps++) begin
				if (cs != 2) begin
					setcnt(16'h0000);
					run({2'(cs), 2'(ps), 4'h0}, 64);
					rdcnt();
					check(cnt, (cs == 1) ? 16'(64 >> ps) : (cs == 0) ? 16'(16 >> ps) : 16'h0000,
						"clock source and prescale");
				end
			end
		end
		for (int osc = 0; osc < 2; osc++) begin
			setcnt(16'h0000);
			wr(ADDR_CONTROL, {4'h8, 1'(osc), 3'h1});
			pulses(5'b10000, 3);
			pulses(5'b01000, 5);
			wr(ADDR_CONTROL, 8'h00);
			rdcnt();
			check(cnt, osc ? 16'h0005 : 16'h0003, "external edges");
		end
		for (int s = 0; s < 4; s++) begin
			for (int lev = 0; lev < 2; lev++) begin
				for (int pol = 0; pol < 2; pol++) begin
					@(posedge clk);
					pins <= lev ? 5'b00111 : 5'b00000;
					t8_ovf <= 1'(lev);
					repeat (4) @(posedge clk);
					wr(ADDR_GATE, {1'b1, 1'(pol), 4'h0, 2'(s)});
					setcnt(16'h0000);
					run(8'h40, 16);
					rdcnt();
					check(cnt, (lev == pol) ? 16'h0010 : 16'h0000, "gated count");
				end
			end
		end
		setcnt(16'h0000);
		wr(ADDR_CONTROL, 8'h40);
		repeat (16) @(posedge clk);
		rdcnt();
		check(cnt, 16'h0000, "counter off");
		@(posedge clk);
		pins <= '0;
		t8_ovf <= 1'b0;
		wr(ADDR_GATE, 8'h00);
		run(8'h70, 4);
		wr(ADDR_COUNT_LOW, 8'h00);
		run(8'h70, 4);
		rdcnt();
		check(cnt, 16'h0000, "prescaler cleared");
		wr(ADDR_INT_MASK, 8'h01);
		setcnt(16'hffff);
		run(8'h40, 2);
		rdcnt();
		check(cnt, 16'h0001, "rollover");
		rdr(ADDR_INT_STATUS);
		check(16'(rd), 16'h0001, "overflow flag");
		check(16'(irq), 16'h0001, "irq raised");
		wr(ADDR_INT_MASK, 8'h00);
		repeat (2) @(posedge clk);
		check(16'(irq), 16'h0000, "irq masked");
		wr(ADDR_INT_MASK, 8'h01);
		wr(ADDR_INT_STATUS, 8'hff);
		repeat (2) @(posedge clk);
		check(16'(irq), 16'h0000, "irq cleared");
		rdr(ADDR_INT_STATUS);
		check(16'(rd), 16'h0000, "flag cleared");
		@(posedge clk);
		asleep <= 1'b1;
		for (int am = 0; am < 2; am++) begin
			setcnt(16'hffff);
			wr(ADDR_CONTROL, {5'h10, 1'(am), 2'h1});
			seen = 1'b0;
			@(posedge clk);
			pins <= 5'b10000;
			for (int i = 0; i < 20; i++) begin
				@(posedge clk);
				#1 if (wake_req !== 1'b0) seen = 1'b1;
			end
			@(posedge clk);
			pins <= '0;
			wr(ADDR_CONTROL, 8'h00);
			check(16'(seen), 16'(am), "wake on overflow");
			rdcnt();
			check(cnt, am ? 16'h0000 : 16'hffff, "count in sleep");
		end
		end_sim();
	end
endmodule

`default_nettype wire
